// ### verilog/cp_irq_pkg.sv
// constants of the content-protection interrupt and status block
//
// Summary of operation
// - set receiver_key_ready once the receiver key sits in receiver_key_regs.
// - outside repeater mode, pause authentication until controller sets receiver_key_valid.
// - clear receiver_key_ready when the controller sets receiver_key_valid.
// - set link_authenticated when authentication succeeds; protected video only after.
// - clear link_authenticated when authentication is lost or restarted.
// - irq_enable resets to zero; every bit is readable and writable.
// - irq_enable bit 0 gates the interrupt output globally.
// - irq_status bit 7 sets on indirect register access complete.
// - irq_status bit 6 sets on receiver detect, or on lock when selected.
// - irq_status bit 5 sets on an interrupt request from the receiver.
// - irq_status bit 4 sets when the repeater key list is ready.
// - irq_status bit 3 sets when the receiver key is ready.
// - irq_status bit 2 sets on authentication failure or loss.
// - irq_status bit 1 sets on successful authentication.
// - irq_status bit 0 is any enabled status; status is read-only, resets zero.
// - the receiver interrupt input is active low.
// - after key-list-ready, pause until the controller sets key_list_valid.
package cp_irq_pkg;

    localparam int          DATA_W            = 8;
    localparam int          ADDR_W            = 8;
    localparam int          NUM_EVT           = 7;

    // register offsets
    localparam logic [7:0]  ADDR_PROT_STATUS  = 8'hC4;
    localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'hC6;
    localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'hC7;

    // reset values
    localparam logic [7:0]  IRQ_ENABLE_RST    = 8'h00;
    localparam logic [7:0]  IRQ_STATUS_RST    = 8'h00;
    localparam logic [7:0]  READ_ZERO         = 8'h00;

    // irq_enable / irq_status bit positions
    localparam int          BIT_GLOBAL        = 0;
    localparam int          BIT_AUTH_SUCCESS  = 1;
    localparam int          BIT_AUTH_FAILURE  = 2;
    localparam int          BIT_KEY_READY     = 3;
    localparam int          BIT_KEY_LIST      = 4;
    localparam int          BIT_RX_REQUEST    = 5;
    localparam int          BIT_RX_DETECT     = 6;
    localparam int          BIT_INDIRECT      = 7;

    // protection_status bit positions
    localparam int          BIT_AUTHENTICATED = 0;
    localparam int          BIT_RX_KEY_READY  = 1;
    localparam int          NUM_PROT          = 2;

endpackage

// ### verilog/flag_if.sv
// set/clear/value bundle between the top and its sticky flag bank
`timescale 1ns/1ps
interface flag_if #(parameter int W = 1);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] q;
    modport owner (input set, input clr, output q);
    modport user  (output set, output clr, input q);
endinterface

// ### verilog/status_flags.sv
// bank of sticky flags where a set wins over a clear in the same cycle
`timescale 1ns/1ps
module status_flags #(
    parameter int W = 1
) (
    input  wire logic   clk,
    input  wire logic   rst,
    flag_if.owner       f
);
    typedef struct packed {
        logic [W-1:0] flags;
    } flag_state_t;

    flag_state_t s_q;
    flag_state_t s_d;

    always_comb
    begin
        s_d       = s_q;
        s_d.flags = (s_q.flags & ~f.clr) | f.set;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign f.q = s_q.flags;
endmodule // status_flags

// ### verilog/edge_detect.sv
// rising-edge detector for synchronous level inputs
`timescale 1ns/1ps
module edge_detect #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] prev;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;

    always_comb
    begin
        s_d      = s_q;
        s_d.prev = din;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign rise = din & ~s_q.prev;
endmodule // edge_detect

// ### verilog/content_protection_irq_status.sv
// interrupt and status logic of the content-protection transmitter
`timescale 1ns/1ps
module content_protection_irq_status (
    input  wire logic        clk,
    input  wire logic        rst,
    // register access from the serial control bus slave
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // events from the authentication engine and link
    input  wire logic        indirect_done,
    input  wire logic        receiver_detect,
    input  wire logic        receiver_lock,
    input  wire logic        receiver_detect_select,
    input  wire logic        receiver_irq_n,
    input  wire logic        key_list_ready,
    input  wire logic        receiver_key_loaded,
    input  wire logic        auth_pass,
    input  wire logic        auth_fail,
    input  wire logic        auth_restart,
    input  wire logic        repeater_mode,
    // controller handshakes from protection_control
    input  wire logic        receiver_key_valid,
    input  wire logic        key_list_valid,
    // outputs
    output logic             auth_pause,
    output logic             receiver_key_ready,
    output logic             link_authenticated,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0] irq_enable;
        logic [7:0] rdata;
        logic       irq;
        logic       list_wait;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic [cp_irq_pkg::NUM_EVT-1:0]  evt_set;
    logic [cp_irq_pkg::NUM_EVT-1:0]  evt_q;
    logic [7:0]                      irq_status;
    logic                            global_int;
    logic [1:0]                      edge_in;
    logic [1:0]                      edge_rise;
    logic                            detect_src;
    logic                            rd_status;
    logic [7:0]                      prot_status;

    flag_if #(.W(cp_irq_pkg::NUM_EVT))  evt_f ();
    flag_if #(.W(cp_irq_pkg::NUM_PROT)) prot_f ();

    ////////////////////////////////////////////////////////////////////////////////
    // level inputs turned into events

    // with the select bit set, the detect event waits for receiver lock
    assign detect_src = receiver_detect_select ? receiver_lock : receiver_detect;
    assign edge_in[0] = detect_src;
    assign edge_in[1] = ~receiver_irq_n;

    edge_detect #(.W(2)) u_edges (
        .clk  (clk),
        .rst  (rst),
        .din  (edge_in),
        .rise (edge_rise)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // sticky interrupt status, bits 7..1 stored as evt bits 6..0

    always_comb
    begin
        evt_set                                = '0;
        evt_set[cp_irq_pkg::BIT_AUTH_SUCCESS-1] = auth_pass;
        evt_set[cp_irq_pkg::BIT_AUTH_FAILURE-1] = auth_fail;
        evt_set[cp_irq_pkg::BIT_KEY_READY-1]    = receiver_key_loaded;
        evt_set[cp_irq_pkg::BIT_KEY_LIST-1]     = key_list_ready;
        evt_set[cp_irq_pkg::BIT_RX_REQUEST-1]   = edge_rise[1];
        evt_set[cp_irq_pkg::BIT_RX_DETECT-1]    = edge_rise[0];
        evt_set[cp_irq_pkg::BIT_INDIRECT-1]     = indirect_done;
    end

    // a status read clears the event bits; a same-cycle event survives
    assign rd_status = reg_rd && (reg_addr == cp_irq_pkg::ADDR_IRQ_STATUS);
    assign evt_f.set = evt_set;
    assign evt_f.clr = {cp_irq_pkg::NUM_EVT{rd_status}};
    assign evt_q     = evt_f.q;

    status_flags #(.W(cp_irq_pkg::NUM_EVT)) u_evt_flags (
        .clk (clk),
        .rst (rst),
        .f   (evt_f)
    );

    assign global_int = |(evt_q
        & s_q.irq_enable[cp_irq_pkg::BIT_INDIRECT:cp_irq_pkg::BIT_AUTH_SUCCESS]);
    assign irq_status = {evt_q, global_int};

    ////////////////////////////////////////////////////////////////////////////////
    // protection status: authenticated and receiver key ready

    assign prot_f.set[cp_irq_pkg::BIT_AUTHENTICATED] = auth_pass;
    assign prot_f.clr[cp_irq_pkg::BIT_AUTHENTICATED] = auth_fail | auth_restart;
    assign prot_f.set[cp_irq_pkg::BIT_RX_KEY_READY]  = receiver_key_loaded;
    assign prot_f.clr[cp_irq_pkg::BIT_RX_KEY_READY]  = receiver_key_valid;

    status_flags #(.W(cp_irq_pkg::NUM_PROT)) u_prot_flags (
        .clk (clk),
        .rst (rst),
        .f   (prot_f)
    );

    assign link_authenticated = prot_f.q[cp_irq_pkg::BIT_AUTHENTICATED];
    assign receiver_key_ready = prot_f.q[cp_irq_pkg::BIT_RX_KEY_READY];
    assign prot_status        = {6'h00, prot_f.q};

    ////////////////////////////////////////////////////////////////////////////////
    // register access, enable register and interrupt output

    always_comb
    begin
        s_d = s_q;
        if (reg_wr && (reg_addr == cp_irq_pkg::ADDR_IRQ_ENABLE))
        begin
            s_d.irq_enable = reg_wdata;
        end
        if (reg_rd)
        begin
            if (reg_addr == cp_irq_pkg::ADDR_IRQ_ENABLE)
                s_d.rdata = s_q.irq_enable;
            else if (reg_addr == cp_irq_pkg::ADDR_IRQ_STATUS)
                s_d.rdata = irq_status;
            else if (reg_addr == cp_irq_pkg::ADDR_PROT_STATUS)
                s_d.rdata = prot_status;
            else
                s_d.rdata = cp_irq_pkg::READ_ZERO;
        end
        // output follows enable and status one cycle later
        s_d.irq = s_q.irq_enable[cp_irq_pkg::BIT_GLOBAL] & global_int;
        // key list handshake: wait until the controller marks it valid
        if (key_list_ready)
            s_d.list_wait = 1'b1;
        else if (key_list_valid)
            s_d.list_wait = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q            <= '0;
            s_q.irq_enable <= cp_irq_pkg::IRQ_ENABLE_RST;
            s_q.rdata      <= cp_irq_pkg::READ_ZERO;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign irq       = s_q.irq;

    // outside repeater mode the engine holds after receiver key ready
    assign auth_pause = (receiver_key_ready & ~repeater_mode) | s_q.list_wait;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_key_ready_set;
        receiver_key_loaded |=> receiver_key_ready;
    endproperty
    a_key_ready_set: assert property (p_key_ready_set)
        else $error("receiver key ready not set after key load");

    property p_pause_on_key;
        (receiver_key_ready && !repeater_mode) |-> auth_pause;
    endproperty
    a_pause_on_key: assert property (p_pause_on_key)
        else $error("authentication not paused while key awaits validation");

    property p_key_ready_clear;
        (receiver_key_valid && !receiver_key_loaded) |=> !receiver_key_ready;
    endproperty
    a_key_ready_clear: assert property (p_key_ready_clear)
        else $error("receiver key ready not cleared by key valid");

    property p_link_authenticated_set;
        auth_pass |=> link_authenticated;
    endproperty
    a_link_authenticated_set: assert property (p_link_authenticated_set)
        else $error("authenticated not set after pass");

    property p_link_authenticated_clear;
        ((auth_fail || auth_restart) && !auth_pass) |=> !link_authenticated;
    endproperty
    a_link_authenticated_clear: assert property (p_link_authenticated_clear)
        else $error("authenticated not cleared on loss or restart");

    property p_enable_write;
        (reg_wr && reg_addr == cp_irq_pkg::ADDR_IRQ_ENABLE)
            |=> (reg_rd && reg_addr == cp_irq_pkg::ADDR_IRQ_ENABLE)
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable register read back differs from write");

    property p_global_gate;
        !s_q.irq_enable[cp_irq_pkg::BIT_GLOBAL] |=> !irq;
    endproperty
    a_global_gate: assert property (p_global_gate)
        else $error("interrupt driven while global enable is clear");

    property p_indirect;
        indirect_done |=> irq_status[cp_irq_pkg::BIT_INDIRECT];
    endproperty
    a_indirect: assert property (p_indirect)
        else $error("indirect access status not set");

    property p_detect_lock;
        (receiver_detect_select && receiver_lock && !$past(receiver_lock)
            && $past(receiver_detect_select))
            |=> irq_status[cp_irq_pkg::BIT_RX_DETECT];
    endproperty
    a_detect_lock: assert property (p_detect_lock)
        else $error("receiver detect status not set on lock");

    property p_rx_request;
        $fell(receiver_irq_n) |=> irq_status[cp_irq_pkg::BIT_RX_REQUEST];
    endproperty
    a_rx_request: assert property (p_rx_request)
        else $error("receiver request status not set on low interrupt");

    property p_key_list;
        key_list_ready |=> (irq_status[cp_irq_pkg::BIT_KEY_LIST] && auth_pause);
    endproperty
    a_key_list: assert property (p_key_list)
        else $error("key list ready not flagged or not paused");

    property p_key_ready_evt;
        receiver_key_loaded |=> irq_status[cp_irq_pkg::BIT_KEY_READY];
    endproperty
    a_key_ready_evt: assert property (p_key_ready_evt)
        else $error("key ready status not set");

    property p_auth_fail_evt;
        auth_fail |=> irq_status[cp_irq_pkg::BIT_AUTH_FAILURE];
    endproperty
    a_auth_fail_evt: assert property (p_auth_fail_evt)
        else $error("auth failure status not set");

    property p_auth_pass_evt;
        auth_pass |=> irq_status[cp_irq_pkg::BIT_AUTH_SUCCESS];
    endproperty
    a_auth_pass_evt: assert property (p_auth_pass_evt)
        else $error("auth success status not set");

    property p_global_read;
        rd_status |=> reg_rdata[cp_irq_pkg::BIT_GLOBAL]
            == $past(|(evt_q & s_q.irq_enable[7:1]));
    endproperty
    a_global_read: assert property (p_global_read)
        else $error("global status bit read wrong");

    property p_irq_follow;
        ##1 irq == $past(s_q.irq_enable[cp_irq_pkg::BIT_GLOBAL] && global_int);
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("interrupt output does not follow enable and status");

    property p_clear_on_read;
        (rd_status && evt_set == '0) |=> evt_q == '0;
    endproperty
    a_clear_on_read: assert property (p_clear_on_read)
        else $error("status read did not clear event bits");

    property p_status_sticky;
        (!rd_status && evt_set == '0) |=> evt_q == $past(evt_q);
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("event bits changed without event or status read");

    property p_status_read;
        rd_status |=> reg_rdata[cp_irq_pkg::BIT_INDIRECT:cp_irq_pkg::BIT_AUTH_SUCCESS]
            == $past(evt_q);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read does not return the event bits");

    property p_prot_read;
        (reg_rd && reg_addr == cp_irq_pkg::ADDR_PROT_STATUS)
            |=> reg_rdata == {6'h00, $past(receiver_key_ready), $past(link_authenticated)};
    endproperty
    a_prot_read: assert property (p_prot_read)
        else $error("protection status read wrong");

    property p_key_hold;
        (receiver_key_ready && !receiver_key_valid) |=> receiver_key_ready;
    endproperty
    a_key_hold: assert property (p_key_hold)
        else $error("receiver key ready dropped without key valid");

    property p_auth_hold;
        (link_authenticated && !auth_fail && !auth_restart) |=> link_authenticated;
    endproperty
    a_auth_hold: assert property (p_auth_hold)
        else $error("authenticated dropped without loss or restart");

    property p_no_pause_repeater;
        (repeater_mode && !s_q.list_wait) |-> !auth_pause;
    endproperty
    a_no_pause_repeater: assert property (p_no_pause_repeater)
        else $error("repeater paused on receiver key ready");

    property p_list_release;
        (key_list_valid && !key_list_ready) |=> !s_q.list_wait;
    endproperty
    a_list_release: assert property (p_list_release)
        else $error("key list pause not released by key list valid");

    property p_detect_plain;
        (!receiver_detect_select && !$past(receiver_detect_select) && $rose(receiver_detect))
            |=> irq_status[cp_irq_pkg::BIT_RX_DETECT];
    endproperty
    a_detect_plain: assert property (p_detect_plain)
        else $error("receiver detect status not set on detect");

    // covers of the main scenarios
    c_irq_raised:     cover property (irq ##1 rd_status ##2 !irq);
    c_key_handshake:  cover property (receiver_key_loaded ##[1:20] receiver_key_valid);
    c_auth_lost:      cover property (link_authenticated ##[1:20] auth_fail);
    c_list_handshake: cover property (key_list_ready ##[1:30] key_list_valid);
    c_detect_lock:    cover property (receiver_detect_select && $rose(receiver_lock));

endmodule // content_protection_irq_status

// ### verif/host_model.sv
// host controller model answering the key and key-list handshakes
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] delay,
    input  wire logic       receiver_key_ready,
    input  wire logic       auth_pause,
    output logic            receiver_key_valid,
    output logic            key_list_valid
);
    int cnt;
    initial
    begin
        receiver_key_valid = 1'b0;
        key_list_valid     = 1'b0;
        cnt                = 0;
    end
    // one handshake pulse per pending item, after delay cycles
    always @(negedge clk)
    begin
        receiver_key_valid <= 1'b0;
        key_list_valid     <= 1'b0;
        if (rst || !(receiver_key_ready || auth_pause) || receiver_key_valid || key_list_valid)
            cnt <= 0;
        else if (cnt < delay)
            cnt <= cnt + 1;
        else if (receiver_key_ready)
            receiver_key_valid <= 1'b1;
        else
            key_list_valid <= 1'b1;
    end
endmodule // host_model

// ### verif/content_protection_irq_status_tb.sv
// self-checking bench of the content-protection interrupt and status block
`timescale 1ns/1ps
module content_protection_irq_status_tb;
    logic       clk, rst, reg_wr, reg_rd, rd_seen, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, delay;
    logic       indirect_done, receiver_detect, receiver_lock, receiver_detect_select;
    logic       receiver_irq_n, key_list_ready, receiver_key_loaded, auth_pass;
    logic       auth_fail, auth_restart, repeater_mode, receiver_key_valid;
    logic       key_list_valid, auth_pause, receiver_key_ready, link_authenticated;
    logic [7:0] exp_q[$];
    logic [31:0] seed;
    int         n_fail, total_checks, cycles;

    content_protection_irq_status DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .indirect_done(indirect_done), .receiver_detect(receiver_detect),
        .receiver_lock(receiver_lock), .receiver_detect_select(receiver_detect_select),
        .receiver_irq_n(receiver_irq_n), .key_list_ready(key_list_ready),
        .receiver_key_loaded(receiver_key_loaded), .auth_pass(auth_pass),
        .auth_fail(auth_fail), .auth_restart(auth_restart), .repeater_mode(repeater_mode),
        .receiver_key_valid(receiver_key_valid), .key_list_valid(key_list_valid),
        .auth_pause(auth_pause), .receiver_key_ready(receiver_key_ready),
        .link_authenticated(link_authenticated), .irq(irq));

    host_model host (.clk(clk), .rst(rst), .delay(delay),
        .receiver_key_ready(receiver_key_ready), .auth_pause(auth_pause),
        .receiver_key_valid(receiver_key_valid), .key_list_valid(key_list_valid));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        tick(1);
        reg_wr    = 1'b0;
    endtask

    // expected read data goes in the queue, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd   = 1'b1;
        exp_q.push_back(exp);
        tick(1);
        reg_rd   = 1'b0;
        tick(1);
    endtask

    // raise the source of status bit b for one cycle
    task automatic ev(input int b);
        case (b)
            7: indirect_done = 1'b1;
            6: receiver_detect = 1'b1;
            5: receiver_irq_n = 1'b0;
            4: key_list_ready = 1'b1;
            3: receiver_key_loaded = 1'b1;
            2: auth_fail = 1'b1;
            default: auth_pass = 1'b1;
        endcase
        tick(1);
        {indirect_done, key_list_ready, receiver_key_loaded, auth_fail, auth_pass} = '0;
        receiver_detect = 1'b0;
        receiver_irq_n  = 1'b1;
    endtask

    // bounded wait for the host to finish its handshake
    task automatic settle();
        int i;
        i = 0;
        while ((receiver_key_ready || auth_pause) && i < 60)
        begin
            tick(1);
            i++;
        end
        check("handshake", {6'h00, auth_pause, receiver_key_ready}, 8'h00);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    always @(posedge clk)
        rd_seen <= reg_rd;

    always @(negedge clk)
        if (rd_seen && exp_q.size() > 0)
            check("reg_rdata", reg_rdata, exp_q.pop_front());

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {reg_wr, reg_rd, rd_seen, indirect_done, receiver_detect, receiver_lock} = '0;
        {receiver_detect_select, key_list_ready, receiver_key_loaded, auth_pass} = '0;
        {auth_fail, auth_restart, repeater_mode} = '0;
        receiver_irq_n = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        delay = 8'h00;
        seed = 32'hF8BD;
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
        rd(8'hC6, 8'h00);
        rd(8'hC7, 8'h00);
        wr(8'hC4, 8'hFF);
        rd(8'hC4, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'hC7, 8'hFF);
        rd(8'hC7, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            wr(8'hC6, seed[7:0]);
            rd(8'hC6, seed[7:0]);
        end
        $display("registers done");
        wr(8'hC6, 8'hFF);
        for (int b = 1; b < 8; b++)
        begin
            ev(b);
            tick(3);
            check("irq", {7'h00, irq}, 8'h01);
            rd(8'hC7, (8'h01 << b) | 8'h01);
            rd(8'hC7, 8'h00);
            check("irq", {7'h00, irq}, 8'h00);
        end
        $display("events done");
        wr(8'hC6, 8'hFE);
        ev(1);
        tick(3);
        check("irq", {7'h00, irq}, 8'h00);
        rd(8'hC7, 8'h03);
        wr(8'hC6, 8'h01);
        ev(2);
        tick(3);
        check("irq", {7'h00, irq}, 8'h00);
        rd(8'hC7, 8'h04);
        receiver_detect_select = 1'b1;
        wr(8'hC6, 8'hFF);
        ev(6);
        tick(3);
        rd(8'hC7, 8'h00);
        receiver_lock = 1'b1;
        tick(3);
        rd(8'hC7, 8'h41);
        receiver_lock = 1'b0;
        receiver_detect_select = 1'b0;
        $display("gating done");
        wr(8'hC6, 8'h00);
        delay = 8'd20;
        ev(3);
        check("key", {6'h00, auth_pause, receiver_key_ready}, 8'h03);
        rd(8'hC4, 8'h02);
        settle();
        repeater_mode = 1'b1;
        ev(3);
        check("key", {6'h00, auth_pause, receiver_key_ready}, 8'h01);
        settle();
        repeater_mode = 1'b0;
        rd(8'hC7, 8'h08);
        ev(4);
        check("pause", {7'h00, auth_pause}, 8'h01);
        settle();
        rd(8'hC7, 8'h10);
        ev(1);
        check("auth", {7'h00, link_authenticated}, 8'h01);
        rd(8'hC4, 8'h01);
        auth_restart = 1'b1;
        tick(1);
        auth_restart = 1'b0;
        check("auth", {7'h00, link_authenticated}, 8'h00);
        ev(1);
        tick(1);
        ev(2);
        check("auth", {7'h00, link_authenticated}, 8'h00);
        rd(8'hC7, 8'h06);
        $display("handshakes done");
        wr(8'hC6, 8'hA5);
        ev(7);
        tick(1);
        ev(1);
        check("pre_reset", {6'h00, irq, link_authenticated}, 8'h03);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        check("reset", {4'h0, irq, auth_pause, receiver_key_ready, link_authenticated}, 8'h00);
        rd(8'hC6, 8'h00);
        rd(8'hC7, 8'h00);
        $display("reset done");
        end_sim();
    end
endmodule // content_protection_irq_status_tb
